// ---- hw/cfr_pkg.sv ----
package cfr_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATE_OFS  = 8'h04;
  localparam logic [7:0] INTST_OFS  = 8'h08;
  localparam logic [7:0] INTMSK_OFS = 8'h0C;
  localparam logic [7:0] OVLCNT_OFS = 8'h10;
  // Control fields and reset values
  localparam int         CTRL_EN_BIT = 0;
  localparam logic       CTRL_RST    = 1'b1;
  localparam logic [4:0] MASK_RST    = 5'h00;
  // Interrupt status bit positions
  localparam int EV_OVL   = 0;
  localparam int EV_CLAMP = 1;
  localparam int EV_THERM = 2;
  localparam int EV_SHDN  = 3;
  localparam int EV_RSTRT = 4;
  localparam int EV_W     = 5;
  // Timing, in printed units, and derived cycle counts at 200 MHz
  localparam longint CLK_HZ      = 200000000;
  localparam longint RESTART_MS  = 1000;
  localparam longint SS_MS       = 8;
  localparam longint CLAMP_US    = 500;
  localparam int     SS_STEPS    = 8;
  localparam int     CHECK_CYC   = 3;
  localparam int unsigned RESTART_CYC = int'(RESTART_MS * CLK_HZ / 1000);
  localparam int unsigned SS_STEP_CYC = int'(SS_MS * CLK_HZ / 1000 / SS_STEPS);
  localparam int unsigned CLAMP_CYC   = int'((CLAMP_US * CLK_HZ + 999999) / 1000000);
  // Switching period in clock cycles (60 kHz oscillator)
  localparam longint OSC_HZ  = 60000;
  localparam logic [15:0] OSC_DIV = 16'(CLK_HZ / OSC_HZ);
  // Overload terminal count: 50 ms in oscillator cycles
  localparam logic [15:0] OVL_TC  = 16'(OSC_HZ * 50 / 1000);
  localparam logic [7:0]  DEB_CYC = 8'h02;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_SOFT    = 3'b001,
    ST_RUN     = 3'b010,
    ST_RESTART = 3'b011,
    ST_THCHK   = 3'b100
  } cfr_state_e;
endpackage : cfr_pkg

// ---- hw/cfr_sequencer.sv ----
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Contract
// RULE_01 - Feedback below off threshold disables error amp, uses external compensation node.
// RULE_02 - At low comp threshold clamp setpoint at light-load floor and skip cycles.
// RULE_03 - Rising comp leaves pulse-frequency operation; full limit at high threshold.
// RULE_04 - Overcurrent comparator ends on-time regardless of pulse-width comparator.
// RULE_05 - Overload counter counts up each cycle ended by overcurrent comparator.
// RULE_06 - Terminal count trips protection and inhibits switching for restart interval.
// RULE_07 - After restart, resume via soft-start; persistent overload trips again.
// RULE_08 - Overload cleared early: counter counts down per cycle, saturating at zero.
// RULE_09 - Fault clearing during restart still waits the full interval.
// RULE_10 - During pending restart, cycle the high-voltage charger between supply thresholds.
// RULE_11 - Clamp current over limit beyond 500 us forces restart with soft-start.
// RULE_12 - Clamp condition ignored during soft-start.
// RULE_13 - Shutdown pin high longer than debounce inhibits switching; the code still fires the check pulses in ST_THCHK.
// RULE_14 - Over-temperature indication inhibits switching.
// RULE_15 - After thermal trip and restart, run three check cycles sampling temperature.
// RULE_16 - Hot during check: another restart; else resume through soft-start.
// RULE_17 - Every start and restart uses eight-step soft-start over about 8 ms.
// RULE_18 - Shutdown debounce and overload terminal count are oscillator-cycle parameters.
// RULE_19 - Undervoltage lockout resets counters, timers, fault states; switch off.
module cfr_sequencer #(
  parameter int unsigned RESTART_CYC_P = cfr_pkg::RESTART_CYC,
  parameter int unsigned SS_STEP_CYC_P = cfr_pkg::SS_STEP_CYC,
  parameter int unsigned CLAMP_CYC_P   = cfr_pkg::CLAMP_CYC,
  parameter logic [15:0] OSC_DIV_P     = cfr_pkg::OSC_DIV,
  parameter logic [15:0] OVL_TC_P      = cfr_pkg::OVL_TC,
  parameter logic [7:0]  DEB_CYC_P     = cfr_pkg::DEB_CYC
) (
  // Clock and undervoltage lockout
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Analog comparator inputs (asynchronous)
  input  wire logic        ocp_cmp_i,
  input  wire logic        pwm_cmp_i,
  input  wire logic        fb_below_off_i,
  input  wire logic        comp_below_low_i,
  input  wire logic        comp_above_high_i,
  input  wire logic        clamp_over_i,
  input  wire logic        shutdown_pin_i,
  input  wire logic        overtemp_i,
  input  wire logic        vcc_below_low_i,
  input  wire logic        vcc_above_high_i,
  // Power stage controls and interrupt request
  output logic             gate_o,
  output logic             ea_disable_o,
  output logic [3:0]       ss_level_o,
  output logic             light_load_floor_o,
  output logic             full_limit_o,
  output logic             pfm_active_o,
  output logic             hv_source_en_o,
  output logic             irq_o
);
  import cfr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [9:0] raw_w;
  logic [9:0] meta_q;
  logic [9:0] sync_q;
  assign raw_w = {vcc_above_high_i, vcc_below_low_i, overtemp_i, shutdown_pin_i, clamp_over_i,
                  comp_above_high_i, comp_below_low_i, fb_below_off_i, pwm_cmp_i, ocp_cmp_i};

  // Two stages; only sync_q is read by logic
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= 10'h000;
      sync_q <= 10'h000;
    end else begin
      meta_q <= raw_w;
      sync_q <= meta_q;
    end
  end

  wire ocp_s    = sync_q[0];
  wire pwm_s    = sync_q[1];
  wire fb_s     = sync_q[2];
  wire clow_s   = sync_q[3];
  wire chigh_s  = sync_q[4];
  wire clamp_s  = sync_q[5];
  wire shdn_s   = sync_q[6];
  wire ot_s     = sync_q[7];
  wire vlow_s   = sync_q[8];
  wire vhigh_s  = sync_q[9];

  //////////////////////////////////////////////////////////////////////////////
  // State and counters
  cfr_state_e  state_q, state_d;
  logic [15:0] osc_q;
  logic [31:0] tmr_q;
  logic [3:0]  ss_step_q;
  logic [15:0] ovl_q;
  logic [31:0] clamp_q;
  logic [7:0]  deb_q;
  logic        shdn_q;
  logic [1:0]  chk_q;
  logic        th_fault_q;
  logic        gate_q;
  logic        ran_q;
  logic        ocp_end_q;
  logic        hv_q;
  logic        ctrl_en_q;
  logic [4:0]  ist_q;
  logic [4:0]  imask_q;

  // Switching cycle boundary from the internal oscillator
  wire cyc_start = (osc_q == 16'h0000);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) osc_q <= 16'h0000;
    else if (osc_q == OSC_DIV_P - 16'h0001) osc_q <= 16'h0000;
    else osc_q <= osc_q + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault detection
  wire   switching = (state_q == ST_SOFT) || (state_q == ST_RUN);
  // Overload trips at terminal count on a cycle still ended by overcurrent
  wire   ovl_trip  = switching && cyc_start && ran_q && ocp_end_q &&
                     (ovl_q == OVL_TC_P - 16'h0001); // see RULE_06
  wire   clamp_trip = (state_q == ST_RUN) && clamp_s &&
                      (clamp_q == CLAMP_CYC_P - 32'h1); // see RULE_11
  wire   stop_req  = !ctrl_en_q || shdn_q; // see RULE_13
  wire   tmr_done  = (state_q == ST_RESTART) ? (tmr_q == RESTART_CYC_P - 32'h1)
                                             : (tmr_q == SS_STEP_CYC_P - 32'h1);
  wire   shdn_rise = !shdn_q && shdn_s && (deb_q == DEB_CYC_P) && cyc_start;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!stop_req && !ot_s) state_d = ST_SOFT; // see RULE_17
      end
      ST_SOFT, ST_RUN: begin
        if (ot_s) state_d = ST_RESTART; // see RULE_14
        else if (ovl_trip || clamp_trip) state_d = ST_RESTART; // see RULE_07
        else if (stop_req) state_d = ST_OFF;
        else if (state_q == ST_SOFT && ss_step_q == 4'(SS_STEPS - 1) && tmr_done)
          state_d = ST_RUN;
      end
      ST_RESTART: begin
        // Only the interval itself ends the wait, whatever the fault does
        if (tmr_done) state_d = th_fault_q ? ST_THCHK : ST_SOFT; // see RULE_09
      end
      ST_THCHK: begin
        if (cyc_start && ot_s) state_d = ST_RESTART; // see RULE_16
        else if (cyc_start && chk_q == 2'(CHECK_CYC)) state_d = ST_SOFT; // see RULE_16
      end
      default: state_d = ST_OFF;
    endcase
  end

  // State register and interval timer; timer restarts on each state change
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin // see RULE_19
      state_q <= ST_OFF;
      tmr_q   <= 32'h0;
    end else begin
      state_q <= state_d;
      tmr_q   <= (state_d != state_q || tmr_done) ? 32'h0 : tmr_q + 32'h1;
    end
  end

  // Soft-start step: zero on entry, one step per interval
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q != ST_SOFT) ss_step_q <= 4'h0; // see RULE_17
    else if (tmr_done && ss_step_q != 4'(SS_STEPS - 1)) ss_step_q <= ss_step_q + 4'h1;
  end

  // Thermal fault memory and check-cycle counter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      th_fault_q <= 1'b0;
      chk_q      <= 2'h0;
    end else begin
      if (switching && ot_s) th_fault_q <= 1'b1;
      else if (state_q == ST_THCHK && state_d == ST_SOFT) th_fault_q <= 1'b0;
      if (state_q != ST_THCHK) chk_q <= 2'h0;
      else if (cyc_start) chk_q <= chk_q + 2'h1; // see RULE_15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gate drive: on at cycle start, off at either comparator
  wire skip_cyc = (state_q == ST_RUN) && clow_s && pwm_s; // see RULE_02
  wire may_sw   = switching || (state_q == ST_THCHK && chk_q != 2'(CHECK_CYC));
  wire gate_on  = cyc_start && may_sw && !skip_cyc && !ot_s && !ocp_s && state_d == state_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gate_q    <= 1'b0;
      ran_q     <= 1'b0;
      ocp_end_q <= 1'b0;
    end else begin
      if (gate_on) gate_q <= 1'b1;
      else if (ocp_s || pwm_s || !may_sw || cyc_start) gate_q <= 1'b0; // see RULE_04
      if (cyc_start) ran_q <= gate_on;
      if (cyc_start) ocp_end_q <= 1'b0;
      else if (gate_q && ocp_s && !pwm_s) ocp_end_q <= 1'b1; // see RULE_05
    end
  end

  // Up/down overload counter, evaluated once per switching cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !switching) ovl_q <= 16'h0000;
    else if (cyc_start && ran_q && ocp_end_q) ovl_q <= ovl_q + 16'h0001; // see RULE_05
    else if (cyc_start && ovl_q != 16'h0000) ovl_q <= ovl_q - 16'h0001; // see RULE_08
  end

  // Clamp duration counter, held clear outside normal running
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q != ST_RUN || !clamp_s) clamp_q <= 32'h0; // see RULE_12
    else clamp_q <= clamp_q + 32'h1;
  end

  // Shutdown pin debounce in oscillator cycles
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      deb_q  <= 8'h00;
      shdn_q <= 1'b0;
    end else if (cyc_start) begin
      if (!shdn_s) begin
        deb_q  <= 8'h00;
        shdn_q <= 1'b0;
      end else if (deb_q == DEB_CYC_P) shdn_q <= 1'b1; // see RULE_18
      else deb_q <= deb_q + 8'h01;
    end
  end

  // Charger hysteresis while a restart is pending
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_q != ST_RESTART) hv_q <= 1'b0;
    else if (vlow_s) hv_q <= 1'b1; // see RULE_10
    else if (vhigh_s) hv_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire acc     = psel_i && penable_i;
  wire hit_ctl = paddr_i == CTRL_OFS;
  wire hit_sta = paddr_i == STATE_OFS;
  wire hit_ist = paddr_i == INTST_OFS;
  wire hit_msk = paddr_i == INTMSK_OFS;
  wire hit_ovl = paddr_i == OVLCNT_OFS;
  wire mapped  = hit_ctl | hit_sta | hit_ist | hit_msk | hit_ovl;
  wire wr      = acc && pwrite_i;
  wire [4:0] ev_w;
  assign ev_w[EV_OVL]   = ovl_trip;
  assign ev_w[EV_CLAMP] = clamp_trip;
  assign ev_w[EV_THERM] = switching && ot_s;
  assign ev_w[EV_SHDN]  = shdn_rise;
  assign ev_w[EV_RSTRT] = (state_q == ST_RESTART) && tmr_done;

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_en_q <= CTRL_RST;
      imask_q   <= MASK_RST;
      ist_q     <= 5'h00;
    end else begin
      if (wr && hit_ctl) ctrl_en_q <= pwdata_i[CTRL_EN_BIT];
      if (wr && hit_msk) imask_q <= pwdata_i[EV_W-1:0];
      ist_q <= (ist_q & ~((wr && hit_ist) ? pwdata_i[EV_W-1:0] : 5'h00)) | ev_w;
    end
  end

  // Read mux from registered state
  assign prdata_o = hit_ctl ? {31'h0, ctrl_en_q} :
                    hit_sta ? {22'h0, hv_q, shdn_q, th_fault_q, gate_q, ss_step_q[2:0],
                               state_q} :
                    hit_ist ? {27'h0, ist_q} :
                    hit_msk ? {27'h0, imask_q} :
                    hit_ovl ? {16'h0, ovl_q} : 32'h0;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign irq_o     = |(ist_q & imask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Power stage outputs
  assign gate_o             = gate_q;
  assign ea_disable_o       = fb_s; // see RULE_01
  assign ss_level_o         = (state_q == ST_SOFT) ? ss_step_q + 4'h1 :
                              (state_q == ST_RUN) ? 4'(SS_STEPS) : 4'h0; // see RULE_17
  assign light_load_floor_o = (state_q == ST_RUN) && clow_s; // see RULE_02
  assign pfm_active_o       = (state_q == ST_RUN) && clow_s && !chigh_s; // see RULE_03
  assign full_limit_o       = (state_q == ST_RUN) && chigh_s; // see RULE_03
  assign hv_source_en_o     = hv_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ocp_gate_off_a: assert property (gate_q && ocp_s && !gate_on |=> !gate_q) // see RULE_04
    else $error("gate stayed on after overcurrent");
  ovl_count_up_a: assert property (switching && state_d == state_q && cyc_start && ran_q
    && ocp_end_q && !ovl_trip |=> ovl_q == $past(ovl_q) + 16'h0001) // see RULE_05
    else $error("overload counter did not increment");
  ovl_trip_a: assert property (ovl_trip && !ot_s |=> state_q == ST_RESTART ##1 !gate_q)
    else $error("overload trip did not enter restart"); // see RULE_06
  ovl_count_dn_a: assert property (switching && state_d == state_q && cyc_start
    && !(ran_q && ocp_end_q) && ovl_q != 16'h0000
    |=> ovl_q == $past(ovl_q) - 16'h0001) // see RULE_08
    else $error("overload counter did not decrement");
  restart_hold_a: assert property (state_q == ST_RESTART && !tmr_done
    |=> state_q == ST_RESTART && !gate_q) // see RULE_09
    else $error("restart left early");
  hv_idle_a: assert property (state_q != ST_RESTART |=> !hv_source_en_o || $past(state_q)
    == ST_RESTART) // see RULE_10
    else $error("charger active outside restart");
  clamp_ignore_a: assert property (state_q == ST_SOFT |-> clamp_q == 32'h0) // see RULE_12
    else $error("clamp counted during soft-start");
  ot_inhibit_a: assert property (switching && ot_s |=> state_q == ST_RESTART) // see RULE_14
    else $error("over-temperature did not inhibit");
  check_len_a: assert property (state_q == ST_THCHK |-> chk_q <= 2'(CHECK_CYC)) // see RULE_15
    else $error("thermal check ran too long");
  ss_entry_a: assert property (state_q == ST_SOFT && $past(state_q) != ST_SOFT
    |-> ss_level_o == 4'h1) // see RULE_17
    else $error("soft-start not from first step");
  ea_follow_a: assert property (ea_disable_o == fb_s) // see RULE_01
    else $error("error amp disable mismatch");

  ovl_trip_c:  cover property (ovl_trip);
  clamp_trip_c: cover property (clamp_trip);
  th_check_c:  cover property (state_q == ST_THCHK ##1 state_q == ST_SOFT);
  irq_c:       cover property (irq_o);
endmodule : cfr_sequencer

// ---- testbench/cfr_stage_model.sv ----
`timescale 1ns/1ps
module cfr_stage_model (
  // Clock and lockout
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Switch gate and charger enable from the block
  input  wire logic gate_i,
  input  wire logic hv_source_en_i,
  // Load command from the bench
  input  wire logic overload_i,
  // Comparator levels back to the block
  output logic      ocp_cmp_o,
  output logic      pwm_cmp_o,
  output logic      vcc_below_low_o,
  output logic      vcc_above_high_o
);
  logic [2:0] on_cnt_q;
  logic [6:0] vcc_q;
  ////////////////////////////////////////////////////////////////////////////
  // Drain current ramps while the switch is on; a shorted load reaches the limit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !gate_i) begin
      on_cnt_q <= 3'h0;
    end else if (on_cnt_q != 3'h7) begin
      on_cnt_q <= on_cnt_q + 3'h1;
    end
  end
  // Only one comparator fires per pulse, so the cause of turn-off is unambiguous
  assign ocp_cmp_o = gate_i & overload_i & (on_cnt_q >= 3'h3);
  assign pwm_cmp_o = gate_i & ~overload_i & (on_cnt_q >= 3'h3);
  ////////////////////////////////////////////////////////////////////////////
  // Supply cap decays by consumption and is topped up by the charger
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vcc_q <= 7'h50;
    end else if (hv_source_en_i && vcc_q < 7'h7E) begin
      vcc_q <= vcc_q + 7'h2;
    end else if (!hv_source_en_i && vcc_q != 7'h00) begin
      vcc_q <= vcc_q - 7'h1;
    end
  end
  assign vcc_below_low_o  = (vcc_q < 7'h14);
  assign vcc_above_high_o = (vcc_q > 7'h50);
endmodule : cfr_stage_model

// ---- testbench/converter_fault_restart_sequencer_test.sv ----
`timescale 1ns/1ps
module converter_fault_restart_sequencer_test;
  import cfr_pkg::*;
  // Shortened counts so restarts take hundreds of cycles, not seconds
  localparam int RS = 200;
  localparam int SS = 20;
  localparam int CL = 50;
  localparam int OD = 10;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, ocp_cmp_i, pwm_cmp_i, vcc_below_low_i, vcc_above_high_i;
  logic        fb_below_off_i = 1'b0, comp_below_low_i = 1'b0, comp_above_high_i = 1'b0;
  logic        clamp_over_i = 1'b0, shutdown_pin_i = 1'b0, overtemp_i = 1'b0, ovl = 1'b0;
  logic        gate_o, ea_disable_o, light_load_floor_o, full_limit_o, pfm_active_o;
  logic        hv_source_en_o, irq_o;
  logic [3:0]  ss_level_o;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          checks_done = 0;
  cfr_sequencer #(.RESTART_CYC_P(RS), .SS_STEP_CYC_P(SS), .CLAMP_CYC_P(CL),
    .OSC_DIV_P(16'(OD)), .OVL_TC_P(16'h0005), .DEB_CYC_P(8'h02)) u_cfr_sequencer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ocp_cmp_i(ocp_cmp_i), .pwm_cmp_i(pwm_cmp_i),
    .fb_below_off_i(fb_below_off_i), .comp_below_low_i(comp_below_low_i),
    .comp_above_high_i(comp_above_high_i), .clamp_over_i(clamp_over_i),
    .shutdown_pin_i(shutdown_pin_i), .overtemp_i(overtemp_i),
    .vcc_below_low_i(vcc_below_low_i), .vcc_above_high_i(vcc_above_high_i), .gate_o(gate_o),
    .ea_disable_o(ea_disable_o), .ss_level_o(ss_level_o),
    .light_load_floor_o(light_load_floor_o), .full_limit_o(full_limit_o),
    .pfm_active_o(pfm_active_o), .hv_source_en_o(hv_source_en_o), .irq_o(irq_o));
  cfr_stage_model u_cfr_stage_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .gate_i(gate_o),
    .hv_source_en_i(hv_source_en_o), .overload_i(ovl), .ocp_cmp_o(ocp_cmp_i),
    .pwm_cmp_o(pwm_cmp_i), .vcc_below_low_o(vcc_below_low_i),
    .vcc_above_high_o(vcc_above_high_i));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; the idle edge at the end keeps back-to-back calls race free
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      apb(1'b0, STATE_OFS, 32'h0);
      if (rd[2:0] === s) break;
    end
    chk({29'h0, rd[2:0]}, {29'h0, s});
  endtask : wait_st
  task automatic wait_lvl(input logic [3:0] k, input int lim);
    for (int i = 0; i < lim && ss_level_o !== k; i++) @(posedge clk_i);
    chk({28'h0, ss_level_o}, {28'h0, k});
  endtask : wait_lvl
  task automatic rst();
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : rst
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_soft();
    for (int k = 1; k <= 8; k++) wait_lvl(4'(k), SS + 8);
    wait_st(ST_RUN, 20);
  endtask : t_soft
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, INTMSK_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h3C, 32'hFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h3C, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask : t_regs
  task automatic t_modes();
    fb_below_off_i <= 1'b1;
    comp_below_low_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({29'h0, ea_disable_o, light_load_floor_o, pfm_active_o}, 32'h7);
    fb_below_off_i <= 1'b0;
    comp_below_low_i <= 1'b0;
    comp_above_high_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({29'h0, ea_disable_o, pfm_active_o, full_limit_o}, 32'h1);
    comp_above_high_i <= 1'b0;
  endtask : t_modes
  task automatic overload_delay();
    int bad;
    bad = 0;
    apb(1'b1, INTMSK_OFS, 32'h1F);
    apb(1'b1, INTST_OFS, 32'h1F);
    ovl <= 1'b1;
    wait_st(ST_RESTART, 40);
    apb(1'b0, INTST_OFS, 32'h0);
    chk({30'h0, rd[EV_OVL], irq_o}, 32'h3);
    // Fault goes away early, yet the switch must stay off for the whole interval
    ovl <= 1'b0;
    repeat (RS - 30) begin
      @(posedge clk_i);
      if (gate_o !== 1'b0) bad++;
    end
    chk(bad, 0);
    ovl <= 1'b1;
    wait_lvl(4'h1, 60);
    wait_st(ST_RESTART, 100);
    ovl <= 1'b0;
    apb(1'b1, INTST_OFS, 32'h1F);
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, INTMSK_OFS, 32'h0);
    wait_st(ST_RUN, 200);
    apb(1'b0, INTST_OFS, 32'h0);
    chk({30'h0, rd[EV_RSTRT], irq_o}, 32'h2);
  endtask : overload_delay
  task automatic t_decay();
    ovl <= 1'b1;
    repeat (3 * OD) @(posedge clk_i);
    ovl <= 1'b0;
    apb(1'b0, OVLCNT_OFS, 32'h0);
    chk({31'h0, rd[15:0] != 16'h0}, 32'h1);
    repeat (8 * OD) @(posedge clk_i);
    apb(1'b0, OVLCNT_OFS, 32'h0);
    chk(rd, 32'h0);
    wait_st(ST_RUN, 1);
  endtask : t_decay
  task automatic t_clamp();
    int n, rises;
    n = 0;
    rises = 0;
    apb(1'b1, CTRL_OFS, 32'h0);
    wait_st(ST_OFF, 10);
    clamp_over_i <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_lvl(4'h8, SS * 8 + 40);
    // Level 8 spans the last soft step plus run; only run time counts
    while (ss_level_o === 4'h8 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n >= CL + SS - 3 && n <= CL + SS + 8}, 32'h1);
    clamp_over_i <= 1'b0;
    apb(1'b0, INTST_OFS, 32'h0);
    chk({31'h0, rd[EV_CLAMP]}, 32'h1);
    repeat (RS - 20) begin
      @(posedge clk_i);
      if (hv_source_en_o === 1'b1 && vcc_above_high_i === 1'b1) rises++;
    end
    chk({31'h0, rises != 0}, 32'h1);
    wait_lvl(4'h1, 40);
  endtask : t_clamp
  task automatic t_shdn();
    wait_st(ST_RUN, 100);
    shutdown_pin_i <= 1'b1;
    repeat (OD) @(posedge clk_i);
    shutdown_pin_i <= 1'b0;
    wait_st(ST_RUN, 1);
    shutdown_pin_i <= 1'b1;
    wait_st(ST_OFF, 20);
    apb(1'b0, INTST_OFS, 32'h0);
    chk({30'h0, rd[EV_SHDN], gate_o}, 32'h2);
    shutdown_pin_i <= 1'b0;
    wait_lvl(4'h1, 60);
  endtask : t_shdn
  task automatic t_therm();
    int rises;
    logic g;
    rises = 0;
    g = 1'b0;
    wait_st(ST_RUN, 100);
    overtemp_i <= 1'b1;
    wait_st(ST_RESTART, 5);
    apb(1'b0, INTST_OFS, 32'h0);
    chk({30'h0, rd[EV_THERM], gate_o}, 32'h2);
    wait_st(ST_THCHK, 100);
    wait_st(ST_RESTART, 20);
    overtemp_i <= 1'b0;
    // Count check pulses from inside the restart until soft-start begins
    for (int i = 0; i < RS + 100 && ss_level_o === 4'h0; i++) begin
      @(posedge clk_i);
      if (gate_o === 1'b1 && !g) rises++;
      g = gate_o;
    end
    chk(rises, 3);
    chk({28'h0, ss_level_o}, 32'h1);
  endtask : t_therm
  task automatic t_reset();
    ovl <= 1'b1;
    repeat (2 * OD + 5) @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, gate_o}, 32'h0);
    ovl <= 1'b0;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, OVLCNT_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, INTST_OFS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst();
    t_soft();
    t_regs();
    t_modes();
    overload_delay();
    t_decay();
    t_clamp();
    t_shdn();
    t_therm();
    t_reset();
    end_sim();
  end
endmodule : converter_fault_restart_sequencer_test
